// ### rtl/ldc_pkg.sv
package ldc_pkg;

    // ****************************************************************
    // register map
    // ****************************************************************
    localparam int ADDR_W = 3;
    localparam int DATA_W = 8;
    localparam logic [ADDR_W-1:0] ADDR_STATUS = 3'h0;
    localparam logic [ADDR_W-1:0] ADDR_LIMIT = 3'h3;
    localparam logic [ADDR_W-1:0] ADDR_DRIVER = 3'h4;
    localparam logic [ADDR_W-1:0] ADDR_INVERT = 3'h6;

    // reset values
    localparam logic [DATA_W-1:0] LIMIT_RST = 8'h00;
    localparam logic [DATA_W-1:0] DRIVER_RST = 8'h01;
    localparam logic [DATA_W-1:0] INVERT_RST = 8'h00;

    // ****************************************************************
    // field positions
    // ****************************************************************
    localparam int LIM_SEL_LO = 6;    // limit_select_lo, hi is one above
    localparam int LIM_OFF = 5;       // limit_off
    localparam int BLANK_LO = 3;      // blanking_sel_lo, hi is one above
    localparam int RETRY_LO = 1;      // retry_time_lo, hi is one above
    localparam int RETRY_ON = 0;      // auto_retry_on
    localparam int DRV_RX_OFF = 7;
    localparam int DRV_WPD = 6;       // weak_pulldown_on
    localparam int DRV_WPU = 5;       // weak_pullup_on
    localparam int DRV_NPN = 3;       // low_side_switch_mode
    localparam int DRV_PP = 2;        // push_pull_mode
    localparam int DRV_Q = 1;         // static_output_level
    localparam int DRV_OFF = 0;       // line_driver_off
    localparam int INV_BIT = 7;       // line_polarity_invert
    localparam int ST_FAULT = 4;
    localparam int ST_LINE_LOW = 1;

    // ****************************************************************
    // timing
    // ****************************************************************
    localparam int CNT_W = 26;
    localparam int CLK_MHZ = 100;
    localparam int BLANK_T0_US = 128;
    localparam int BLANK_T1_US = 500;
    localparam int BLANK_T2_MS = 1;
    localparam int BLANK_T3_MS = 5;
    localparam int OFF_T0_MS = 50;
    localparam int OFF_T1_MS = 100;
    localparam int OFF_T2_MS = 200;
    localparam int OFF_T3_MS = 500;
    localparam logic [CNT_W-1:0] BLANK0_CYC = CNT_W'(BLANK_T0_US * CLK_MHZ);
    localparam logic [CNT_W-1:0] BLANK1_CYC = CNT_W'(BLANK_T1_US * CLK_MHZ);
    localparam logic [CNT_W-1:0] BLANK2_CYC = CNT_W'(BLANK_T2_MS * 1000 * CLK_MHZ);
    localparam logic [CNT_W-1:0] BLANK3_CYC = CNT_W'(BLANK_T3_MS * 1000 * CLK_MHZ);
    localparam logic [CNT_W-1:0] OFF0_CYC = CNT_W'(OFF_T0_MS * 1000 * CLK_MHZ);
    localparam logic [CNT_W-1:0] OFF1_CYC = CNT_W'(OFF_T1_MS * 1000 * CLK_MHZ);
    localparam logic [CNT_W-1:0] OFF2_CYC = CNT_W'(OFF_T2_MS * 1000 * CLK_MHZ);
    localparam logic [CNT_W-1:0] OFF3_CYC = CNT_W'(OFF_T3_MS * 1000 * CLK_MHZ);

    // fault sequencer states
    typedef enum logic [1:0] {
        LDC_IDLE,
        LDC_BLANK,
        LDC_OFF_WAIT,
        LDC_THERM_WAIT
    } ldc_state_t;

endpackage

// ### rtl/ldc_fault_if.sv
`timescale 1ns/1ps
interface ldc_fault_if;
    logic [1:0] blank_sel;
    logic [1:0] retry_sel;
    logic retry_on;
    logic fault_raw;
    logic temp_ok;
    logic drive_allow;
    logic fault_flag;

    // register side
    modport cfg (
        output blank_sel, retry_sel, retry_on, fault_raw, temp_ok,
        input drive_allow, fault_flag
    );
    // sequencer side
    modport tmr (
        input blank_sel, retry_sel, retry_on, fault_raw, temp_ok,
        output drive_allow, fault_flag
    );
endinterface

// ### rtl/ldc_fault_timer.sv
`timescale 1ns/1ps
module ldc_fault_timer #(
    parameter logic [ldc_pkg::CNT_W-1:0] BLANK0_CYC = ldc_pkg::BLANK0_CYC,
    parameter logic [ldc_pkg::CNT_W-1:0] BLANK1_CYC = ldc_pkg::BLANK1_CYC,
    parameter logic [ldc_pkg::CNT_W-1:0] BLANK2_CYC = ldc_pkg::BLANK2_CYC,
    parameter logic [ldc_pkg::CNT_W-1:0] BLANK3_CYC = ldc_pkg::BLANK3_CYC,
    parameter logic [ldc_pkg::CNT_W-1:0] OFF0_CYC = ldc_pkg::OFF0_CYC,
    parameter logic [ldc_pkg::CNT_W-1:0] OFF1_CYC = ldc_pkg::OFF1_CYC,
    parameter logic [ldc_pkg::CNT_W-1:0] OFF2_CYC = ldc_pkg::OFF2_CYC,
    parameter logic [ldc_pkg::CNT_W-1:0] OFF3_CYC = ldc_pkg::OFF3_CYC
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic sys_rst_i,
    // configuration and status
    ldc_fault_if.tmr flt
);
    import ldc_pkg::*;

    ldc_state_t state_r, state_nxt;
    logic [CNT_W-1:0] cnt_r, cnt_nxt;
    logic flag_r, flag_nxt;
    logic [CNT_W-1:0] blank_end;
    logic [CNT_W-1:0] off_end;
    logic blank_done;
    logic off_done;

    // selected windows, counted from zero
    assign blank_end = (flt.blank_sel == 2'h0) ? BLANK0_CYC - 1'b1 :
                       (flt.blank_sel == 2'h1) ? BLANK1_CYC - 1'b1 :
                       (flt.blank_sel == 2'h2) ? BLANK2_CYC - 1'b1 : BLANK3_CYC - 1'b1;
    assign off_end = (flt.retry_sel == 2'h0) ? OFF0_CYC - 1'b1 :
                     (flt.retry_sel == 2'h1) ? OFF1_CYC - 1'b1 :
                     (flt.retry_sel == 2'h2) ? OFF2_CYC - 1'b1 : OFF3_CYC - 1'b1;
    assign blank_done = cnt_r >= blank_end;
    assign off_done = cnt_r >= off_end;

    // driver is held off only after a confirmed fault
    assign flt.drive_allow = (state_r == LDC_IDLE) || (state_r == LDC_BLANK);
    assign flt.fault_flag = flag_r;

    // sequencer; a fault shorter than the blanking window is forgotten
    always_comb begin
        state_nxt = state_r;
        cnt_nxt = cnt_r + 1'b1;
        flag_nxt = flag_r && flt.fault_raw;
        unique case (state_r)
            LDC_IDLE: begin
                cnt_nxt = '0;
                if (flt.fault_raw) begin
                    state_nxt = LDC_BLANK;
                end
            end
            LDC_BLANK: begin
                if (!flt.fault_raw) begin
                    state_nxt = LDC_IDLE;
                end else if (blank_done) begin
                    flag_nxt = 1'b1;
                    cnt_nxt = '0;
                    state_nxt = flt.retry_on ? LDC_OFF_WAIT : LDC_THERM_WAIT;
                end
            end
            LDC_OFF_WAIT: begin
                if (off_done) begin
                    state_nxt = LDC_IDLE;
                end
            end
            LDC_THERM_WAIT: begin
                cnt_nxt = '0;
                if (flt.temp_ok) begin
                    state_nxt = LDC_IDLE;
                end
            end
        endcase
    end

    // state registers
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            state_r <= LDC_IDLE;
            cnt_r <= '0;
            flag_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            flag_r <= flag_nxt;
        end
    end

    property p_blank_first;
        @(posedge clk_i) disable iff (sys_rst_i)
        $rose(flag_r) |-> $past(state_r) == LDC_BLANK && $past(blank_done);
    endproperty
    a_blank_first: assert property (p_blank_first) else $error("fault flagged before blanking");

    property p_retry_off;
        @(posedge clk_i) disable iff (sys_rst_i)
        state_r == LDC_OFF_WAIT && !off_done |=> state_r == LDC_OFF_WAIT && !flt.drive_allow;
    endproperty
    a_retry_off: assert property (p_retry_off) else $error("retry off-time cut short");

    property p_therm_hold;
        @(posedge clk_i) disable iff (sys_rst_i)
        state_r == LDC_THERM_WAIT && !flt.temp_ok |=> state_r == LDC_THERM_WAIT;
    endproperty
    a_therm_hold: assert property (p_therm_hold) else $error("driver back before cooling");

    c_retry: cover property (@(posedge clk_i) disable iff (sys_rst_i)
        state_r == LDC_OFF_WAIT ##1 state_r == LDC_IDLE);
    c_therm: cover property (@(posedge clk_i) disable iff (sys_rst_i)
        state_r == LDC_THERM_WAIT ##1 state_r == LDC_IDLE);
endmodule

// ### rtl/ldc_line_cfg.sv
`timescale 1ns/1ps
// Operation
// - limit select field picks 50, 100, 200 or 250 mA limit
// - limit_off set removes the current limit; clear enforces selected limit
// - blanking field picks 128 us, 500 us, 1 ms or 5 ms
// - fault is flagged only after it persists for the blanking time
// - retry field picks 50, 100, 200 or 500 ms off-time
// - auto-retry on: driver off for the off-time, then back on by itself
// - auto-retry off: driver back on only once die has cooled
// - all config bits read/write; reads change nothing
// - receiver disable puts receive output in high impedance
// - weak pull-down sink follows its bit
// - weak pull-up source follows its bit
// - push_pull_mode set gives push-pull, clear gives open-drain
// - open-drain picks low-side or high-side switch; ignored in push-pull
// - static level set: line high, high switch on, or low switch off
// - static level clear with enable low or driver off: line high impedance
// - static level clear, enable high, driver on: line is inverse of data
// - line_driver_off keeps the driver high impedance whatever enable does
// - reset clears all three registers except line_driver_off, which is set
// - polarity invert makes line follow data and receiver follow line
// - fault status set once fault outlasts blanking time, clears when it goes
module ldc_line_cfg #(
    parameter logic [ldc_pkg::CNT_W-1:0] BLANK0_CYC = ldc_pkg::BLANK0_CYC,
    parameter logic [ldc_pkg::CNT_W-1:0] BLANK1_CYC = ldc_pkg::BLANK1_CYC,
    parameter logic [ldc_pkg::CNT_W-1:0] BLANK2_CYC = ldc_pkg::BLANK2_CYC,
    parameter logic [ldc_pkg::CNT_W-1:0] BLANK3_CYC = ldc_pkg::BLANK3_CYC,
    parameter logic [ldc_pkg::CNT_W-1:0] OFF0_CYC = ldc_pkg::OFF0_CYC,
    parameter logic [ldc_pkg::CNT_W-1:0] OFF1_CYC = ldc_pkg::OFF1_CYC,
    parameter logic [ldc_pkg::CNT_W-1:0] OFF2_CYC = ldc_pkg::OFF2_CYC,
    parameter logic [ldc_pkg::CNT_W-1:0] OFF3_CYC = ldc_pkg::OFF3_CYC
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic sys_rst_i,
    // register port
    input wire logic [ldc_pkg::ADDR_W-1:0] addr_i,
    input wire logic [ldc_pkg::DATA_W-1:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [ldc_pkg::DATA_W-1:0] rdata_o,
    // transmit side pins
    input wire logic transmit_enable_in_i,
    input wire logic tx_data_i,
    // line sense and fault detectors
    input wire logic line_level_i,
    input wire logic overcurrent_i,
    input wire logic overtemp_i,
    input wire logic temp_cool_i,
    // line driver controls
    output logic high_switch_on_o,
    output logic low_switch_on_o,
    output logic [1:0] limit_select_o,
    output logic limit_enable_o,
    output logic weak_pulldown_on_o,
    output logic weak_pullup_on_o,
    // receive output pin
    output logic rx_o,
    output logic rx_oe_n_o,
    // status
    output logic line_fault_o
);
    import ldc_pkg::*;

    // ****************************************************************
    // pin synchronisers
    // ****************************************************************
    localparam int NSYNC = 6;
    logic [NSYNC-1:0] sync1_r;
    logic [NSYNC-1:0] sync2_r;
    logic transmit_enable_in_s;
    logic tx_s;
    logic line_s;
    logic ocur_s;
    logic otemp_s;
    logic cool_s;

    // first stage is read by the second stage only
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            sync1_r <= '0;
            sync2_r <= '0;
        end else begin
            sync1_r <= {transmit_enable_in_i, tx_data_i, line_level_i,
                        overcurrent_i, overtemp_i, temp_cool_i};
            sync2_r <= sync1_r;
        end
    end

    assign transmit_enable_in_s = sync2_r[5];
    assign tx_s = sync2_r[4];
    assign line_s = sync2_r[3];
    assign ocur_s = sync2_r[2];
    assign otemp_s = sync2_r[1];
    assign cool_s = sync2_r[0];

    // ****************************************************************
    // registers
    // ****************************************************************
    logic [DATA_W-1:0] limit_cfg_r;
    logic [DATA_W-1:0] driver_cfg_r;
    logic invert_r;
    logic [DATA_W-1:0] rdata_nxt;
    logic [DATA_W-1:0] status_w;
    logic wr_limit;
    logic wr_driver;
    logic wr_invert;

    // write decode; status is read only, other addresses ignore writes
    assign wr_limit = wr_i && (addr_i == ADDR_LIMIT);
    assign wr_driver = wr_i && (addr_i == ADDR_DRIVER);
    assign wr_invert = wr_i && (addr_i == ADDR_INVERT);

    // register storage; reads have no side effect at all
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            limit_cfg_r <= LIMIT_RST;
            driver_cfg_r <= DRIVER_RST;
            invert_r <= INVERT_RST[INV_BIT];
        end else begin
            if (wr_limit) begin
                limit_cfg_r <= wdata_i;
            end
            if (wr_driver) begin
                driver_cfg_r <= wdata_i;
            end
            if (wr_invert) begin
                invert_r <= wdata_i[INV_BIT];
            end
        end
    end

    // status view of live conditions
    assign status_w = (DATA_W'(line_fault_o) << ST_FAULT)
                    | (DATA_W'(!line_s) << ST_LINE_LOW);

    // read mux; unmapped addresses read as zero
    assign rdata_nxt = !rd_i ? '0 :
                       (addr_i == ADDR_STATUS) ? status_w :
                       (addr_i == ADDR_LIMIT) ? limit_cfg_r :
                       (addr_i == ADDR_DRIVER) ? driver_cfg_r :
                       (addr_i == ADDR_INVERT) ? (DATA_W'(invert_r) << INV_BIT) : '0;

    // read data stands only in the cycle after the strobe
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            rdata_o <= '0;
        end else begin
            rdata_o <= rdata_nxt;
        end
    end

    // ****************************************************************
    // fault sequencer
    // ****************************************************************
    ldc_fault_if flt ();

    assign flt.blank_sel = limit_cfg_r[BLANK_LO+1:BLANK_LO];
    assign flt.retry_sel = limit_cfg_r[RETRY_LO+1:RETRY_LO];
    assign flt.retry_on = limit_cfg_r[RETRY_ON];
    assign flt.fault_raw = ocur_s || otemp_s;
    assign flt.temp_ok = cool_s;

    ldc_fault_timer #(
        .BLANK0_CYC(BLANK0_CYC),
        .BLANK1_CYC(BLANK1_CYC),
        .BLANK2_CYC(BLANK2_CYC),
        .BLANK3_CYC(BLANK3_CYC),
        .OFF0_CYC(OFF0_CYC),
        .OFF1_CYC(OFF1_CYC),
        .OFF2_CYC(OFF2_CYC),
        .OFF3_CYC(OFF3_CYC)
    ) u_timer (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .flt(flt)
    );

    // ****************************************************************
    // line driver decode
    // ****************************************************************
    logic drv_off;
    logic stat_q;
    logic pp_mode;
    logic npn_mode;
    logic drive_on;
    logic drive_lvl;
    logic hs_nxt;
    logic ls_nxt;
    logic rx_nxt;

    assign drv_off = driver_cfg_r[DRV_OFF];
    assign stat_q = driver_cfg_r[DRV_Q];
    assign pp_mode = driver_cfg_r[DRV_PP];
    assign npn_mode = driver_cfg_r[DRV_NPN];

    // driver off and a confirmed fault both win over enable and static level
    assign drive_on = !drv_off && flt.drive_allow && (stat_q || transmit_enable_in_s);
    // static level forces high, else data inverted unless polarity swapped
    assign drive_lvl = stat_q ? 1'b1 : (invert_r ? tx_s : !tx_s);

    // switch selection; npn bit only matters in open-drain
    assign hs_nxt = drive_on && drive_lvl && (pp_mode || !npn_mode);
    assign ls_nxt = drive_on && !drive_lvl && (pp_mode || npn_mode);
    assign rx_nxt = invert_r ? line_s : !line_s;

    // registered pin controls; reset leaves everything released
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            high_switch_on_o <= 1'b0;
            low_switch_on_o <= 1'b0;
            limit_select_o <= 2'h0;
            limit_enable_o <= 1'b0;
            weak_pulldown_on_o <= 1'b0;
            weak_pullup_on_o <= 1'b0;
            rx_o <= 1'b0;
            rx_oe_n_o <= 1'b1;
            line_fault_o <= 1'b0;
        end else begin
            high_switch_on_o <= hs_nxt;
            low_switch_on_o <= ls_nxt;
            limit_select_o <= limit_cfg_r[LIM_SEL_LO+1:LIM_SEL_LO];
            limit_enable_o <= !limit_cfg_r[LIM_OFF];
            weak_pulldown_on_o <= driver_cfg_r[DRV_WPD];
            weak_pullup_on_o <= driver_cfg_r[DRV_WPU];
            rx_o <= rx_nxt;
            rx_oe_n_o <= driver_cfg_r[DRV_RX_OFF];
            line_fault_o <= flt.fault_flag;
        end
    end

    // ****************************************************************
    // assertions
    // ****************************************************************
    // a switch pair shorting the line would be destructive
    property p_no_shoot;
        @(posedge clk_i) disable iff (sys_rst_i)
        !(high_switch_on_o && low_switch_on_o);
    endproperty
    a_no_shoot: assert property (p_no_shoot) else $error("both switches on");

    property p_read_limit;
        @(posedge clk_i) disable iff (sys_rst_i)
        rd_i && addr_i == ADDR_LIMIT |=> rdata_o == $past(limit_cfg_r);
    endproperty
    a_read_limit: assert property (p_read_limit) else $error("limit readback wrong");

    property p_read_quiet;
        @(posedge clk_i) disable iff (sys_rst_i)
        rd_i |=> $stable(limit_cfg_r) && $stable(driver_cfg_r);
    endproperty
    a_read_quiet: assert property (p_read_quiet) else $error("read changed a register");

    property p_reset_val;
        @(posedge clk_i)
        $past(sys_rst_i) && !sys_rst_i |-> limit_cfg_r == LIMIT_RST && driver_cfg_r == DRIVER_RST;
    endproperty
    a_reset_val: assert property (p_reset_val) else $error("bad reset value");

    property p_limit;
        @(posedge clk_i) disable iff (sys_rst_i)
        wr_limit ##1 !wr_limit |=>
            limit_select_o == $past(limit_cfg_r[LIM_SEL_LO+1:LIM_SEL_LO])
            && limit_enable_o == !$past(limit_cfg_r[LIM_OFF]);
    endproperty
    a_limit: assert property (p_limit) else $error("limit outputs wrong");

    property p_drv_off;
        @(posedge clk_i) disable iff (sys_rst_i)
        drv_off [*2] |-> !high_switch_on_o && !low_switch_on_o;
    endproperty
    a_drv_off: assert property (p_drv_off) else $error("driver active while off");

    property p_idle_hiz;
        @(posedge clk_i) disable iff (sys_rst_i)
        !stat_q && !transmit_enable_in_s |=> !high_switch_on_o && !low_switch_on_o;
    endproperty
    a_idle_hiz: assert property (p_idle_hiz) else $error("line driven without enable");

    property p_tx_inv;
        @(posedge clk_i) disable iff (sys_rst_i)
        !stat_q && transmit_enable_in_s && !drv_off && flt.drive_allow && pp_mode && !invert_r
            |=> high_switch_on_o == !$past(tx_s) && low_switch_on_o == $past(tx_s);
    endproperty
    a_tx_inv: assert property (p_tx_inv) else $error("line not inverse of data");

    property p_static;
        @(posedge clk_i) disable iff (sys_rst_i)
        stat_q && !drv_off && flt.drive_allow
            |=> !low_switch_on_o && (high_switch_on_o == $past(pp_mode || !npn_mode));
    endproperty
    a_static: assert property (p_static) else $error("static level drive wrong");

    property p_rx_hiz;
        @(posedge clk_i) disable iff (sys_rst_i)
        driver_cfg_r[DRV_RX_OFF] |=> rx_oe_n_o;
    endproperty
    a_rx_hiz: assert property (p_rx_hiz) else $error("receiver driven while off");

    property p_pulls;
        @(posedge clk_i) disable iff (sys_rst_i)
        wr_driver |=> ##1 weak_pulldown_on_o == $past(wdata_i[DRV_WPD], 2)
            && weak_pullup_on_o == $past(wdata_i[DRV_WPU], 2);
    endproperty
    a_pulls: assert property (p_pulls) else $error("weak pull mismatch");

    property p_fault_clear;
        @(posedge clk_i) disable iff (sys_rst_i)
        !flt.fault_raw [*3] |-> !line_fault_o;
    endproperty
    a_fault_clear: assert property (p_fault_clear) else $error("fault flag stuck");

    // a confirmed fault must release the line whatever the static level asks
    property p_fault_off;
        @(posedge clk_i) disable iff (sys_rst_i)
        !flt.drive_allow |=> !high_switch_on_o && !low_switch_on_o;
    endproperty
    a_fault_off: assert property (p_fault_off) else $error("driver on during fault hold");

    property p_rx_on;
        @(posedge clk_i) disable iff (sys_rst_i)
        !driver_cfg_r[DRV_RX_OFF] |=> !rx_oe_n_o;
    endproperty
    a_rx_on: assert property (p_rx_on) else $error("receiver released while on");

    property p_pnp_side;
        @(posedge clk_i) disable iff (sys_rst_i)
        !pp_mode && !npn_mode |=> !low_switch_on_o;
    endproperty
    a_pnp_side: assert property (p_pnp_side) else $error("low switch used in high-side mode");

    property p_npn_side;
        @(posedge clk_i) disable iff (sys_rst_i)
        !pp_mode && npn_mode |=> !high_switch_on_o;
    endproperty
    a_npn_side: assert property (p_npn_side) else $error("high switch used in low-side mode");

    // the status flag may only rise once the driver is already held off
    property p_flag_late;
        @(posedge clk_i) disable iff (sys_rst_i)
        $rose(line_fault_o) |-> !flt.drive_allow;
    endproperty
    a_flag_late: assert property (p_flag_late) else $error("fault shown while driver allowed");

    c_drive: cover property (@(posedge clk_i) disable iff (sys_rst_i)
        wr_driver ##3 high_switch_on_o);
    c_fault: cover property (@(posedge clk_i) disable iff (sys_rst_i)
        $rose(line_fault_o));
    c_npn: cover property (@(posedge clk_i) disable iff (sys_rst_i)
        low_switch_on_o && !pp_mode);
endmodule

// ### testbench/ldc_line_load.sv
`timescale 1ns/1ps
// ****
// sensor line load model
// ****
module ldc_line_load (
    // clock
    input wire logic clk_i,
    // switches and pulls from the driver
    input wire logic hs_i,
    input wire logic ls_i,
    input wire logic wpu_i,
    input wire logic wpd_i,
    // bench controls
    input wire logic short_i,
    input wire logic hot_i,
    // sensed values
    output logic line_o,
    output logic oc_o,
    output logic ot_o,
    output logic cool_o
);
    logic last_r = 1'b0;
    // a floating line flips every cycle so a stale level never passes
    always @(posedge clk_i) begin
        last_r <= line_o;
    end
    assign line_o = hs_i ? 1'b1 : ls_i ? 1'b0 : wpu_i ? 1'b1 : wpd_i ? 1'b0 : ~last_r;
    // a short draws current only while a switch is on
    assign oc_o = short_i & (hs_i | ls_i);
    assign ot_o = hot_i;
    assign cool_o = ~hot_i;
endmodule

// ### testbench/tb_ldc_line_cfg.sv
`timescale 1ns/1ps
module tb_ldc_line_cfg;
    import ldc_pkg::*;
    logic clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic [2:0] addr_i = 3'h0;
    logic [7:0] wdata_i = 8'h00;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic transmit_enable_in = 1'b0;
    logic txd = 1'b0;
    logic short_on = 1'b0;
    logic hot = 1'b0;
    logic line, oc, ot, cool, hs, ls, lim_en, wpd, wpu, rx, rx_oe_n, fault;
    logic [1:0] lim_sel;
    logic [7:0] rdata_o;
    int err_total = 0;
    int n_checks = 0;
    int n;
    // blanking code 0 runs at its real length; codes 1 to 3 are shortened
    int bl[4] = '{int'(BLANK0_CYC), 16, 24, 32};
    int off[2] = '{40, 60};
    // cfg, transmit_enable_in, txd, expected high and low switch
    logic [11:0] drv[12] = '{12'h044, 12'h0a4, 12'h040, 12'h05c, 12'h062, 12'h022,
        12'h0a0, 12'h08d, 12'h0c4, 12'h0ca, 12'h00a, 12'h00c};
    initial begin
        forever #5 clk_i = ~clk_i;
    end
    // retry codes 2 and 3 keep their real length and are only checked as long holds
    ldc_line_cfg #(.BLANK1_CYC(26'h10), .BLANK2_CYC(26'h18), .BLANK3_CYC(26'h20),
        .OFF0_CYC(26'h28), .OFF1_CYC(26'h3c)) uut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .transmit_enable_in_i(transmit_enable_in), .tx_data_i(txd), .line_level_i(line),
        .overcurrent_i(oc), .overtemp_i(ot), .temp_cool_i(cool), .high_switch_on_o(hs),
        .low_switch_on_o(ls), .limit_select_o(lim_sel), .limit_enable_o(lim_en),
        .weak_pulldown_on_o(wpd), .weak_pullup_on_o(wpu), .rx_o(rx), .rx_oe_n_o(rx_oe_n),
        .line_fault_o(fault));
    ldc_line_load load (.clk_i(clk_i), .hs_i(hs), .ls_i(ls), .wpu_i(wpu), .wpd_i(wpd),
        .short_i(short_on), .hot_i(hot), .line_o(line), .oc_o(oc), .ot_o(ot), .cool_o(cool));
    // ****
    // shared tasks
    // ****
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic tick(input int k);
        repeat (k) @(posedge clk_i);
        #1;
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask
    // read data stands only in the cycle after the strobe
    task automatic rchk(input logic [2:0] a, input logic [7:0] e);
        @(posedge clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1;
        check(rdata_o, e);
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // bounded wait for the fault flag (0) or the high switch (1)
    task automatic wait_hi(input int which, input int bound, output int k);
        k = 0;
        while ((which == 0 ? fault : hs) !== 1'b1) begin
            tick(1);
            k++;
            if (k > bound) begin
                err_total++;
                close_out();
            end
        end
    endtask
    // ****
    // main sequence
    // ****
    initial begin
        repeat (6) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        rchk(ADDR_LIMIT, 8'h00);
        rchk(ADDR_DRIVER, 8'h01);
        wr(ADDR_DRIVER, 8'hfe);
        rchk(ADDR_DRIVER, 8'hfe);
        rchk(ADDR_DRIVER, 8'hfe);
        rchk(3'h7, 8'h00);
        $display("registers done");
        for (int c = 0; c < 8; c++) begin
            wr(ADDR_LIMIT, {c[2:0], 5'h00});
            tick(2);
            check({lim_sel, lim_en}, {c[2:1], ~c[0]});
        end
        wr(ADDR_DRIVER, 8'ha1);
        tick(6);
        check({rx_oe_n, wpd, wpu}, 3'b101);
        wr(ADDR_DRIVER, 8'h41);
        tick(6);
        check({rx_oe_n, wpd, wpu, rx}, 4'b0101);
        $display("pins done");
        foreach (drv[i]) begin
            wr(ADDR_DRIVER, drv[i][11:4]);
            transmit_enable_in <= drv[i][3];
            txd <= drv[i][2];
            tick(6);
            check({hs, ls}, drv[i][1:0]);
        end
        // polarity swap: line follows data, receiver follows line
        wr(ADDR_INVERT, 8'h80);
        rchk(ADDR_INVERT, 8'h80);
        wr(ADDR_DRIVER, 8'h04);
        tick(6);
        check({hs, ls}, 2'b10);
        wr(ADDR_DRIVER, 8'h41);
        tick(6);
        check(rx, 1'b0);
        wr(ADDR_INVERT, 8'h00);
        $display("drive done");
        // pull-down keeps the line defined while the driver is held off
        wr(ADDR_DRIVER, 8'h46);
        for (int b = 0; b < 4; b++) begin
            wr(ADDR_LIMIT, {3'h0, b[1:0], b[1:0], 1'b1});
            tick(6);
            short_on <= 1'b1;
            wait_hi(0, bl[b] + 20, n);
            check({n >= bl[b], n <= bl[b] + 6}, 2'b11);
            short_on <= 1'b0;
            if (b < 2) begin
                wait_hi(1, 200, n);
                check({n >= off[b] - 6, n <= off[b] + 6}, 2'b11);
            end else begin
                // long codes must outlast code 1; code 0 then ends the hold early
                tick(off[1] + 20);
                check({hs, ls}, 2'b00);
                wr(ADDR_LIMIT, {3'h0, b[1:0], 3'h1});
                wait_hi(1, 20, n);
            end
            tick(4);
            check(fault, 1'b0);
        end
        short_on <= 1'b1;
        tick(10);
        short_on <= 1'b0;
        tick(50);
        check(fault, 1'b0);
        wr(ADDR_LIMIT, 8'h08);
        hot <= 1'b1;
        wait_hi(0, 40, n);
        tick(130);
        check({hs, ls}, 2'b00);
        rchk(ADDR_STATUS, 8'h12);
        hot <= 1'b0;
        wait_hi(1, 20, n);
        $display("faults done");
        close_out();
    end
endmodule
